/* File: include/cpu_core_pkg.sv */
// ****************************************************************
// Shared constants for the flag, program counter and table unit
// ****************************************************************
package cpu_core_pkg;

	localparam int DATA_W  = 8;
	localparam int PC_W    = 21;
	localparam int UPPER_W = 5;
	localparam int OFS_W   = 11;
	localparam int NFLAGS  = 5;

	// Status flag bit positions
	localparam int FLAG_C  = 0;
	localparam int FLAG_HC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_VF = 3;
	localparam int FLAG_N  = 4;

	// Which flags each instruction group writes
	localparam logic [NFLAGS-1:0] MASK_NONE   = 5'h00;
	localparam logic [NFLAGS-1:0] MASK_ARITH  = 5'h1f;
	localparam logic [NFLAGS-1:0] MASK_LOGIC  = 5'h14;
	localparam logic [NFLAGS-1:0] MASK_CLR    = 5'h04;
	localparam logic [NFLAGS-1:0] MASK_RCARRY = 5'h15;

	localparam logic [PC_W-1:0]   PC_WORD_STEP = 21'h000002;
	localparam logic [PC_W-1:0]   PC_RESET     = 21'h000000;
	localparam logic [DATA_W-1:0] BYTE_ZERO    = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONE     = 8'h01;
	localparam logic [DATA_W-1:0] NEG_LIMIT    = 8'h80;

	// Table pointer update variants
	typedef enum logic [1:0] {
		TBL_KEEP    = 2'h0,
		TBL_POSTINC = 2'h1,
		TBL_POSTDEC = 2'h2,
		TBL_PREINC  = 2'h3
	} tbl_mode_e;

	typedef enum logic [4:0] {
		OP_NOP      = 5'h00,
		OP_ADD      = 5'h01,
		OP_ADDC     = 5'h02,
		OP_SUB      = 5'h03,
		OP_SUBB     = 5'h04,
		OP_INC      = 5'h05,
		OP_DEC      = 5'h06,
		OP_AND      = 5'h07,
		OP_IOR      = 5'h08,
		OP_XOR      = 5'h09,
		OP_CLR      = 5'h0a,
		OP_RLC      = 5'h0b,
		OP_RRC      = 5'h0c,
		OP_RLNC     = 5'h0d,
		OP_RRNC     = 5'h0e,
		OP_NEG      = 5'h0f,
		OP_MOVE     = 5'h10,
		OP_TABRD    = 5'h11,
		OP_TABWR    = 5'h12,
		OP_GOTO     = 5'h13,
		OP_CALL     = 5'h14,
		OP_BRA      = 5'h15,
		OP_UPBANK   = 5'h16,
		OP_LONGCALL = 5'h17
	} op_e;

	typedef enum logic [2:0] {
		SK_RUN    = 3'b001,
		SK_FIRST  = 3'b010,
		SK_SECOND = 3'b100
	} skip_e;

	typedef enum logic [1:0] {
		TR_IDLE = 2'b01,
		TR_WAIT = 2'b10
	} tread_e;

endpackage

/* File: rtl/flag_alu.sv */
`timescale 1ns/1ps
// ****************************************************************
// Result and status flag computation
// ****************************************************************
module flag_alu (
	input  wire logic [7:0] opCode,    // Operation code
	input  wire logic [7:0] operand,   // Register or literal operand
	input  wire logic [7:0] wReg,      // Working register
	input  wire logic       carryIn,   // Current carry flag
	output logic      [7:0] result,    // Result byte
	output logic      [4:0] flagNext,  // Candidate flag values
	output logic      [4:0] flagMask   // Flags written by this op
);
	logic [7:0] addend;
	logic       cin;
	logic [8:0] sum;
	logic [4:0] nib;
	logic       useAdder;

	always_comb begin
		addend   = wReg;
		cin      = 1'b0;
		useAdder = 1'b1;
		case (opCode[4:0])
			cpu_core_pkg::OP_ADD:  addend = wReg;
			cpu_core_pkg::OP_ADDC: cin = carryIn;
			cpu_core_pkg::OP_SUB: begin
				addend = ~wReg;
				cin    = 1'b1;
			end
			cpu_core_pkg::OP_SUBB: begin
				addend = ~wReg;
				cin    = carryIn;
			end
			cpu_core_pkg::OP_INC:  addend = cpu_core_pkg::BYTE_ONE;
			cpu_core_pkg::OP_DEC: begin
				addend = ~cpu_core_pkg::BYTE_ONE;
				cin    = 1'b1;
			end
			default: useAdder = 1'b0;
		endcase
	end

	assign sum = {1'b0, operand} + {1'b0, addend} + {8'h00, cin};
	assign nib = {1'b0, operand[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};

	always_comb begin
		result   = operand;
		flagNext = 5'h00;
		flagMask = cpu_core_pkg::MASK_NONE;
		if (useAdder) begin
			result                          = sum[7:0];
			flagMask                        = cpu_core_pkg::MASK_ARITH;
			flagNext[cpu_core_pkg::FLAG_C]  = sum[8];
			flagNext[cpu_core_pkg::FLAG_HC] = nib[4];
			flagNext[cpu_core_pkg::FLAG_VF] = (operand[7] == addend[7]) && (sum[7] != operand[7]);
		end else begin
			case (opCode[4:0])
				cpu_core_pkg::OP_AND: begin
					result   = operand & wReg;
					flagMask = cpu_core_pkg::MASK_LOGIC;
				end
				cpu_core_pkg::OP_IOR: begin
					result   = operand | wReg;
					flagMask = cpu_core_pkg::MASK_LOGIC;
				end
				cpu_core_pkg::OP_XOR: begin
					result   = operand ^ wReg;
					flagMask = cpu_core_pkg::MASK_LOGIC;
				end
				cpu_core_pkg::OP_CLR: begin
					result   = cpu_core_pkg::BYTE_ZERO;
					flagMask = cpu_core_pkg::MASK_CLR;
				end
				cpu_core_pkg::OP_RLC: begin
					result                         = {operand[6:0], carryIn};
					flagNext[cpu_core_pkg::FLAG_C] = operand[7];
					flagMask                       = cpu_core_pkg::MASK_RCARRY;
				end
				cpu_core_pkg::OP_RRC: begin
					result                         = {carryIn, operand[7:1]};
					flagNext[cpu_core_pkg::FLAG_C] = operand[0];
					flagMask                       = cpu_core_pkg::MASK_RCARRY;
				end
				cpu_core_pkg::OP_RLNC: begin
					result   = {operand[6:0], operand[7]};
					flagMask = cpu_core_pkg::MASK_LOGIC;
				end
				cpu_core_pkg::OP_RRNC: begin
					result   = {operand[0], operand[7:1]};
					flagMask = cpu_core_pkg::MASK_LOGIC;
				end
				cpu_core_pkg::OP_NEG: begin
					result                          = 8'h00 - operand;
					flagMask                        = cpu_core_pkg::MASK_ARITH;
					flagNext[cpu_core_pkg::FLAG_C]  = (operand == cpu_core_pkg::BYTE_ZERO);
					flagNext[cpu_core_pkg::FLAG_HC] = (operand[3:0] == 4'h0);
					flagNext[cpu_core_pkg::FLAG_VF] = (operand == cpu_core_pkg::NEG_LIMIT);
				end
				default: flagMask = cpu_core_pkg::MASK_NONE;
			endcase
		end
		flagNext[cpu_core_pkg::FLAG_Z] = (result == cpu_core_pkg::BYTE_ZERO);
		flagNext[cpu_core_pkg::FLAG_N] = result[7];
	end

endmodule

/* File: rtl/table_ptr_unit.sv */
`timescale 1ns/1ps
// ****************************************************************
// Table pointer byte address and update
// ****************************************************************
module table_ptr_unit (
	input  wire logic [20:0] tablePointer, // Current pointer
	input  wire logic [1:0]  tblMode,      // Update variant
	output logic      [20:0] accessAddr,   // Byte address used now
	output logic      [20:0] nextPointer   // Pointer after the access
);
	localparam logic [20:0] ONE = 21'h000001;

	always_comb begin
		accessAddr  = tablePointer;
		nextPointer = tablePointer;
		case (tblMode)
			cpu_core_pkg::TBL_POSTINC: nextPointer = tablePointer + ONE;
			cpu_core_pkg::TBL_POSTDEC: nextPointer = tablePointer - ONE;
			cpu_core_pkg::TBL_PREINC: begin
				accessAddr  = tablePointer + ONE;
				nextPointer = tablePointer + ONE;
			end
			default: nextPointer = tablePointer;
		endcase
	end

endmodule

/* File: rtl/cpu_flags_pc_table_access.sv */
`timescale 1ns/1ps
// Summary of operation
// - Negative flag reflects result of affecting ops
// - Arithmetic ops update all five flags
// - AND, OR, XOR update only Z, N
// - Clear sets Z, other flags untouched
// - Carry rotates update C,Z,N; others Z,N
// - Negate gives two's complement, all five flags
// - Register move changes no flag
// - Table reads and writes change no flag
// - Bank literal and long call not decoded
// - Counter counts bytes, offsets doubled
// - Low byte read copies high, upper to latches
// - Low byte write loads high, upper from latches
// - Table pointer byte address, 8-bit transfers
// - One instruction per table read or write
// - Skipped second word executes as no-op
module cpu_flags_pc_table_access (
	input  wire logic        clk,           // 200 MHz clock
	input  wire logic        rst_b,         // Asynchronous reset, active low
	input  wire logic        opValid,       // An instruction word issues
	input  wire logic [4:0]  opCode,        // Decoded operation
	input  wire logic        opTwoWord,     // Issued word opens a two-word op
	input  wire logic [7:0]  operand,       // Register or literal operand
	input  wire logic [7:0]  wReg,          // Working register value
	input  wire logic [1:0]  tblMode,       // Table pointer variant
	input  wire logic [10:0] braOffset,     // Signed word offset for branch
	input  wire logic [19:0] jumpTarget,    // Word target for jump or call
	input  wire logic        skipTaken,     // Next word is to be skipped
	input  wire logic        pcLowRd,       // Counter low byte read strobe
	input  wire logic        pcLowWr,       // Counter low byte write strobe
	input  wire logic [7:0]  pcLowWrData,   // Data for low byte write
	input  wire logic        latchHighWr,   // Write high latch
	input  wire logic        latchUpperWr,  // Write upper latch
	input  wire logic [7:0]  latchData,     // Data for latch writes
	input  wire logic        tblPtrWr,      // Load table pointer
	input  wire logic [20:0] tblPtrData,    // Table pointer load value
	input  wire logic        tblLatchWr,    // Load table latch
	input  wire logic [7:0]  tblLatchData,  // Table latch load value
	input  wire logic [7:0]  progRdData,    // Program memory read byte
	output logic      [7:0]  result,        // Result byte
	output logic             resultValid,   // Result strobe
	output logic      [4:0]  statusFlags,   // Negative, overflow, zero, digit carry, carry
	output logic      [20:0] pc,            // Program counter, byte address
	output logic      [7:0]  pcLowRead,     // Value returned by low byte read
	output logic      [7:0]  pcHighLatch,   // High latch
	output logic      [4:0]  pcUpperLatch,  // Upper latch
	output logic      [20:0] tablePointer,  // Table pointer
	output logic      [7:0]  tableLatch,    // Table latch
	output logic      [20:0] progAddr,      // Program memory byte address
	output logic             progRe,        // Program memory read pulse
	output logic             progWe,        // Program memory write pulse
	output logic      [7:0]  progWrData,    // Program memory write byte
	output logic             illegalOp,     // Undecoded op seen
	output logic             opSkipped      // Word executed as a no-op
);
	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rstSync1;
	logic rst_bSync;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1  <= 1'b0;
			rst_bSync <= 1'b0;
		end else begin
			rstSync1  <= 1'b1;
			rst_bSync <= rstSync1;
		end
	end

	// ****************************************************************
	// Decode and skip handling
	// ****************************************************************
	cpu_core_pkg::skip_e skipState;
	logic                execOp;
	logic                isIllegal;

	function automatic logic is_op(input logic [4:0] code, input cpu_core_pkg::op_e op);
		is_op = (code == op);
	endfunction

	assign isIllegal = is_op(opCode, cpu_core_pkg::OP_UPBANK)
		|| is_op(opCode, cpu_core_pkg::OP_LONGCALL);
	assign execOp = opValid && (skipState == cpu_core_pkg::SK_RUN) && !isIllegal;

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			skipState <= cpu_core_pkg::SK_RUN;
		end else if (opValid) begin
			case (skipState)
				cpu_core_pkg::SK_RUN: if (skipTaken) skipState <= cpu_core_pkg::SK_FIRST;
				cpu_core_pkg::SK_FIRST: begin
					if (opTwoWord)
						skipState <= cpu_core_pkg::SK_SECOND;
					else
						skipState <= cpu_core_pkg::SK_RUN;
				end
				cpu_core_pkg::SK_SECOND: skipState <= cpu_core_pkg::SK_RUN;
				default: skipState <= cpu_core_pkg::SK_RUN;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			opSkipped <= 1'b0;
			illegalOp <= 1'b0;
		end else begin
			opSkipped <= opValid && (skipState != cpu_core_pkg::SK_RUN);
			illegalOp <= opValid && (skipState == cpu_core_pkg::SK_RUN) && isIllegal;
		end
	end

	// ****************************************************************
	// Result and status flags
	// ****************************************************************
	logic [7:0] aluResult;
	logic [4:0] flagNext;
	logic [4:0] flagMask;

	flag_alu uAlu (
		.opCode   ({3'h0, opCode}),
		.operand  (operand),
		.wReg     (wReg),
		.carryIn  (statusFlags[cpu_core_pkg::FLAG_C]),
		.result   (aluResult),
		.flagNext (flagNext),
		.flagMask (flagMask)
	);

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			statusFlags <= 5'h00;
		end else if (execOp) begin
			statusFlags <= (statusFlags & ~flagMask) | (flagNext & flagMask);
		end
	end

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			result      <= 8'h00;
			resultValid <= 1'b0;
		end else begin
			resultValid <= execOp && (opCode >= cpu_core_pkg::OP_ADD)
				&& (opCode <= cpu_core_pkg::OP_MOVE);
			if (execOp)
				result <= aluResult;
		end
	end

	// ****************************************************************
	// Program counter and its latches
	// ****************************************************************
	logic [20:0] braByteOfs;

	assign braByteOfs = {{9{braOffset[10]}}, braOffset, 1'b0};

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			pc <= cpu_core_pkg::PC_RESET;
		end else if (pcLowWr) begin
			pc <= {pcUpperLatch, pcHighLatch, pcLowWrData};
		end else if (opValid) begin
			if (execOp && (is_op(opCode, cpu_core_pkg::OP_GOTO)
				|| is_op(opCode, cpu_core_pkg::OP_CALL)))
				pc <= {jumpTarget, 1'b0};
			else if (execOp && is_op(opCode, cpu_core_pkg::OP_BRA))
				pc <= pc + cpu_core_pkg::PC_WORD_STEP + braByteOfs;
			else
				pc <= pc + cpu_core_pkg::PC_WORD_STEP;
		end
	end

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			pcHighLatch  <= 8'h00;
			pcUpperLatch <= 5'h00;
			pcLowRead    <= 8'h00;
		end else if (pcLowRd) begin
			pcLowRead    <= pc[7:0];
			pcHighLatch  <= pc[15:8];
			pcUpperLatch <= pc[20:16];
		end else begin
			if (latchHighWr)
				pcHighLatch <= latchData;
			if (latchUpperWr)
				pcUpperLatch <= latchData[4:0];
		end
	end

	// ****************************************************************
	// Table read and write
	// ****************************************************************
	logic [20:0]           accessAddr;
	logic [20:0]           nextPointer;
	logic                  prog_mem_byte_read_op;
	logic                  prog_mem_byte_write_op;

	table_ptr_unit uTbl (
		.tablePointer (tablePointer),
		.tblMode      (tblMode),
		.accessAddr   (accessAddr),
		.nextPointer  (nextPointer)
	);

	assign prog_mem_byte_read_op = execOp && is_op(opCode, cpu_core_pkg::OP_TABRD);
	assign prog_mem_byte_write_op = execOp && is_op(opCode, cpu_core_pkg::OP_TABWR);

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			tablePointer <= 21'h000000;
		end else if (prog_mem_byte_read_op || prog_mem_byte_write_op) begin
			tablePointer <= nextPointer;
		end else if (tblPtrWr) begin
			tablePointer <= tblPtrData;
		end
	end

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			progAddr   <= 21'h000000;
			progRe     <= 1'b0;
			progWe     <= 1'b0;
			progWrData <= 8'h00;
		end else begin
			progRe <= prog_mem_byte_read_op;
			progWe <= prog_mem_byte_write_op;
			if (prog_mem_byte_read_op || prog_mem_byte_write_op)
				progAddr <= accessAddr;
			if (prog_mem_byte_write_op)
				progWrData <= tableLatch;
		end
	end

	always_ff @(posedge clk or negedge rst_bSync) begin
		if (!rst_bSync) begin
			tableLatch <= 8'h00;
		end else if (progRe) begin
			tableLatch <= progRdData;
		end else if (tblLatchWr) begin
			tableLatch <= tblLatchData;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_bSync);

	property p_neg_flag;
		execOp && flagMask[cpu_core_pkg::FLAG_N] |=> statusFlags[cpu_core_pkg::FLAG_N] == result[7];
	endproperty
	a_neg_flag: assert property (p_neg_flag) else $error("negative flag differs from result");

	property p_logic_keeps_carry;
		execOp && (is_op(opCode, cpu_core_pkg::OP_AND) || is_op(opCode, cpu_core_pkg::OP_XOR))
			|=> $stable(statusFlags[1:0]) && $stable(statusFlags[cpu_core_pkg::FLAG_VF]);
	endproperty
	a_logic_keeps_carry: assert property (p_logic_keeps_carry) else $error("logic op changed carry or overflow");

	property p_clear;
		execOp && is_op(opCode, cpu_core_pkg::OP_CLR)
			|=> statusFlags[cpu_core_pkg::FLAG_Z] && statusFlags[4:3] == $past(statusFlags[4:3])
			&& statusFlags[1:0] == $past(statusFlags[1:0]);
	endproperty
	a_clear: assert property (p_clear) else $error("clear op flags wrong");

	property p_move_no_flags;
		execOp && (is_op(opCode, cpu_core_pkg::OP_MOVE) || is_op(opCode, cpu_core_pkg::OP_TABRD))
			|=> $stable(statusFlags);
	endproperty
	a_move_no_flags: assert property (p_move_no_flags) else $error("move or table op changed flags");

	property p_add_carry;
		execOp && is_op(opCode, cpu_core_pkg::OP_ADD)
			|=> statusFlags[cpu_core_pkg::FLAG_C] == ($past(operand) + $past(wReg) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_pc_step;
		opValid && !pcLowWr && !is_op(opCode, cpu_core_pkg::OP_GOTO)
			&& !is_op(opCode, cpu_core_pkg::OP_CALL) && !is_op(opCode, cpu_core_pkg::OP_BRA)
			|=> pc == $past(pc) + cpu_core_pkg::PC_WORD_STEP;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("counter did not step two bytes");

	property p_low_read;
		pcLowRd |=> pcHighLatch == $past(pc[15:8]) && pcUpperLatch == $past(pc[20:16]);
	endproperty
	a_low_read: assert property (p_low_read) else $error("latches not loaded on low byte read");

	property p_low_write;
		pcLowWr |=> pc == {$past(pcUpperLatch), $past(pcHighLatch), $past(pcLowWrData)};
	endproperty
	a_low_write: assert property (p_low_write) else $error("counter not loaded from latches");

	property p_table_read;
		prog_mem_byte_read_op |=> progRe && progAddr == $past(accessAddr) ##1 tableLatch == $past(progRdData);
	endproperty
	a_table_read: assert property (p_table_read) else $error("table read transfer wrong");

	property p_skip_second;
		opValid && skipState == cpu_core_pkg::SK_FIRST && opTwoWord ##1 opValid
			|=> opSkipped && $stable(statusFlags);
	endproperty
	a_skip_second: assert property (p_skip_second) else $error("second word not skipped");

	property p_illegal;
		opValid && skipState == cpu_core_pkg::SK_RUN && isIllegal |=> illegalOp && $stable(statusFlags);
	endproperty
	a_illegal: assert property (p_illegal) else $error("removed op was executed");

	c_table_write: cover property (prog_mem_byte_write_op ##1 progWe);
	c_skip_two_word: cover property (skipState == cpu_core_pkg::SK_SECOND ##1 opSkipped);
	c_low_round_trip: cover property (pcLowRd ##[1:4] pcLowWr);
	c_negate: cover property (execOp && is_op(opCode, cpu_core_pkg::OP_NEG));

endmodule

/* File: verif/prog_mem_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Program memory seen by the table unit
// ****************************************************************
module prog_mem_model (
	input  wire logic        clk,        // Core clock
	input  wire logic [20:0] progAddr,   // Byte address
	input  wire logic        progRe,     // Read pulse
	input  wire logic        progWe,     // Write pulse
	input  wire logic [7:0]  progWrData, // Write byte
	output logic      [7:0]  progRdData  // Read byte
);
	logic [7:0] mem [256];
	logic [7:0] lastRd = 8'h00;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
	always @(posedge clk) begin
		if (progWe) mem[progAddr[7:0]] <= progWrData;
		if (progRe) lastRd <= mem[progAddr[7:0]];
	end
	// Outside a read the bus shows the inverse of the last byte, never stale data
	always_comb progRdData = progRe ? mem[progAddr[7:0]] : ~lastRd;
endmodule

/* File: verif/cpu_flags_pc_table_access_tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module cpu_flags_pc_table_access_tb;
	logic        clk, rst_b, opValid, opTwoWord, skipTaken, pcLowRd, pcLowWr;
	logic        latchHighWr, latchUpperWr, tblPtrWr, tblLatchWr, resultValid;
	logic        progRe, progWe, illegalOp, opSkipped;
	logic [4:0]  opCode, statusFlags, pcUpperLatch, expFlags;
	logic [7:0]  operand, wReg, pcLowWrData, latchData, tblLatchData, progRdData;
	logic [7:0]  result, pcLowRead, pcHighLatch, tableLatch, progWrData;
	logic [1:0]  tblMode, md;
	logic [10:0] braOffset;
	logic [19:0] jumpTarget;
	logic [20:0] tblPtrData, pc, tablePointer, progAddr, expPc, expPtr, acc;
	logic [12:0] note;
	logic [12:0] notes [$];
	logic [7:0]  edges [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
	int          err_count, total_checks, skipN, nSkip, nIll, expSkips, expIll;
	integer      seed;

	cpu_flags_pc_table_access cpu_flags_pc_table_access_i (.clk, .rst_b, .opValid, .opCode,
		.opTwoWord, .operand, .wReg, .tblMode, .braOffset, .jumpTarget, .skipTaken, .pcLowRd,
		.pcLowWr, .pcLowWrData, .latchHighWr, .latchUpperWr, .latchData, .tblPtrWr,
		.tblPtrData, .tblLatchWr, .tblLatchData, .progRdData, .result, .resultValid,
		.statusFlags, .pc, .pcLowRead, .pcHighLatch, .pcUpperLatch, .tablePointer, .tableLatch,
		.progAddr, .progRe, .progWe, .progWrData, .illegalOp, .opSkipped);
	prog_mem_model prog_mem_model_i (.clk, .progAddr, .progRe, .progWe, .progWrData,
		.progRdData);

	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string n, input logic [20:0] e, g);
		total_checks++;
		if (e !== g) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wrap_up();
		if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic idle(input int n);
		@(posedge clk);
		{opValid, skipTaken, opTwoWord, pcLowRd, pcLowWr} <= '0;
		{latchHighWr, latchUpperWr, tblPtrWr, tblLatchWr} <= '0;
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Drives one word and notes the result and flags it should give
	task automatic issue(input logic [4:0] op, input logic [7:0] a, w, input logic sk, two);
		logic [8:0] s;
		logic [4:0] lo, m;
		logic [7:0] x, b, r;
		logic       ci, c, ov;
		@(posedge clk);
		opValid <= 1;
		opCode <= op;
		operand <= a;
		wReg <= w;
		skipTaken <= sk;
		opTwoWord <= two;
		tblMode <= md;
		if (skipN > 0) begin
			skipN = skipN - 1 + int'(two);
			expSkips++;
			expPc = expPc + 21'h2;
			return;
		end
		skipN = int'(sk);
		if (op == 5'h13 || op == 5'h14) expPc = {jumpTarget, 1'b0};
		else if (op == 5'h15) expPc = expPc + 21'h2 + {{9{braOffset[10]}}, braOffset, 1'b0};
		else expPc = expPc + 21'h2;
		if (op inside {5'h16, 5'h17}) expIll++;
		if (op < 5'h01 || op > 5'h10) return;
		x = a;
		b = w;
		ci = 0;
		c = expFlags[0];
		case (op)
			5'h02: ci = c;
			5'h03: {b, ci} = {~w, 1'b1};
			5'h04: {b, ci} = {~w, c};
			5'h05: {b, ci} = 9'h001;
			5'h06: b = 8'hff;
			5'h0f: {x, b, ci} = {8'h00, ~a, 1'b1};
			default: ;
		endcase
		s = x + b + 9'(ci);
		lo = x[3:0] + b[3:0] + 5'(ci);
		r = s[7:0];
		ov = (x[7] == b[7]) && (r[7] != x[7]);
		case (op)
			5'h07: r = a & w;
			5'h08: r = a | w;
			5'h09: r = a ^ w;
			5'h0a: r = 8'h00;
			5'h0b: r = {a[6:0], c};
			5'h0c: r = {c, a[7:1]};
			5'h0d: r = {a[6:0], a[7]};
			5'h0e: r = {a[0], a[7:1]};
			5'h10: r = a;
			default: ;
		endcase
		c = (op == 5'h0b) ? a[7] : (op == 5'h0c) ? a[0] : s[8];
		m = (op inside {5'h07, 5'h08, 5'h09, 5'h0d, 5'h0e}) ? 5'h14 : (op == 5'h0a) ? 5'h04 :
			(op inside {5'h0b, 5'h0c}) ? 5'h15 : (op == 5'h10) ? 5'h00 : 5'h1f;
		expFlags = (expFlags & ~m) | ({r[7], ov, r == 8'h00, lo[4], c} & m);
		notes.push_back({r, expFlags});
	endtask

	always @(posedge clk) begin
		if (illegalOp === 1'b1) nIll++;
		if (opSkipped === 1'b1) nSkip++;
		if (resultValid === 1'b1) begin
			note = (notes.size() > 0) ? notes.pop_front() : 13'h1fff;
			chk("result", 21'(note[12:5]), 21'(result));
			chk("flags", 21'(note[4:0]), 21'(statusFlags));
		end
	end

	initial begin
		#100000;
		err_count++;
		wrap_up();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = 32'h2dc2;
		{opValid, opTwoWord, skipTaken, pcLowRd, pcLowWr, latchHighWr, latchUpperWr} = '0;
		{tblPtrWr, tblLatchWr, opCode, operand, wReg, tblMode, md, braOffset} = '0;
		{jumpTarget, pcLowWrData, latchData, tblPtrData, tblLatchData} = '0;
		{expPc, expFlags, skipN} = '0;
		rst_b = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1;
		idle(4);
		chk("pc", 21'h0, pc);
		for (int k = 0; k < 320; k++)
			issue(5'(1 + k % 16), k < 256 ? edges[k / 16 % 4] : 8'($random(seed)),
				k < 256 ? edges[k / 64] : 8'($random(seed)), 0, 0);
		issue(5'h16, 8'h01, 8'h01, 0, 0);
		issue(5'h17, 8'h01, 8'h01, 0, 0);
		@(posedge clk);
		opValid <= 1'b0;
		jumpTarget <= 20'($random(seed));
		braOffset <= 11'h7f3;
		idle(2);
		chk("pc", expPc, pc);
		chk("flags", 21'(expFlags), 21'(statusFlags));
		issue(5'h01, 8'h11, 8'h22, 1, 0);
		issue(5'h13, 8'h00, 8'h00, 0, 1);
		issue(5'h00, 8'h00, 8'h00, 0, 0);
		issue(5'h01, 8'h11, 8'h22, 1, 0);
		issue(5'h01, 8'h55, 8'h01, 0, 0);
		issue(5'h02, 8'h80, 8'h80, 0, 0);
		issue(5'h14, 8'h00, 8'h00, 0, 1);
		issue(5'h00, 8'h00, 8'h00, 0, 0);
		issue(5'h15, 8'h00, 8'h00, 0, 0);
		idle(2);
		chk("pc", expPc, pc);
		chk("skips", 21'(expSkips), 21'(nSkip));
		chk("illegal", 21'(expIll), 21'(nIll));
		@(posedge clk);
		pcLowRd <= 1;
		idle(1);
		chk("pcLowRead", 21'(expPc[7:0]), 21'(pcLowRead));
		chk("pcHighLatch", 21'(expPc[15:8]), 21'(pcHighLatch));
		chk("pcUpperLatch", 21'(expPc[20:16]), 21'(pcUpperLatch));
		@(posedge clk);
		{latchHighWr, latchUpperWr, latchData} <= {2'b11, 8'h3c};
		idle(1);
		@(posedge clk);
		{pcLowWr, pcLowWrData} <= {1'b1, 8'ha6};
		idle(1);
		expPc = {5'h1c, 8'h3c, 8'ha6};
		chk("pc", expPc, pc);
		@(posedge clk);
		{tblPtrWr, tblPtrData} <= {1'b1, 21'h1f00f2};
		idle(1);
		expPtr = 21'h1f00f2;
		for (int k = 0; k < 4; k++) begin
			md = 2'(k);
			acc = (md == 2'h3) ? expPtr + 21'h1 : expPtr;
			expPtr = (md == 2'h2) ? expPtr - 21'h1 : (md == 2'h0) ? expPtr : expPtr + 21'h1;
			issue(5'h11, 8'h00, 8'h00, 0, 0);
			idle(2);
			chk("tableLatch", 21'(acc[7:0] ^ 8'h5a), 21'(tableLatch));
			chk("tablePointer", expPtr, tablePointer);
		end
		@(posedge clk);
		{tblLatchWr, tblLatchData} <= {1'b1, 8'hc3};
		idle(1);
		md = 2'h2;
		acc = expPtr;
		issue(5'h12, 8'h00, 8'h00, 0, 0);
		idle(2);
		chk("tablePointer", acc - 21'h1, tablePointer);
		@(posedge clk);
		{tblPtrWr, tblPtrData} <= {1'b1, acc};
		idle(1);
		md = 2'h0;
		issue(5'h11, 8'h00, 8'h00, 0, 0);
		idle(2);
		chk("tableLatch", 21'h0000c3, 21'(tableLatch));
		chk("flags", 21'(expFlags), 21'(statusFlags));
		chk("pc", expPc, pc);
		chk("pending", 21'h0, 21'(notes.size()));
		wrap_up();
	end
endmodule
